//--- hw/dbc_top.sv
// Purpose: window-three base registers, subsystem id, capability pointer and null rom base
// Assumes: apb3 slave, zero wait states while clk_en is high, setup values held stable by the loader
// Notes: decoder answers one cycle after each request; clk_en low freezes all state and stalls the bus with pready low
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "dbc_params.svh"

module dbc_top (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DBC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // setup values from the private register space
  input wire dbc_pkg::dbc_setup_type setup,
  // address decode and translation
  input wire dbc_pkg::dbc_req_type req,
  output dbc_pkg::dbc_res_type res
);
  import dbc_pkg::*;

  dbc_state_type st_reg;
  dbc_state_type st_next;

  logic xfer;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic window_en;
  logic [19:0] mask_lo;
  logic [31:0] base_lo_word;
  logic [31:0] rd_word;
  logic hit32;
  logic hit64;
  logic [31:0] xlat_lo;

  // waits only come from a frozen clock enable
  assign pready = clk_en;
  assign xfer = psel && penable && clk_en;
  assign wr_en = xfer && pwrite;
  assign rd_en = xfer && !pwrite;
  assign mask_lo = setup.mask_lo[`DBC_BASE_MSB:`DBC_BASE_LSB];

  always_comb begin
    unique case (paddr)
      `DBC_OFS_BASE, `DBC_OFS_UPPER, `DBC_OFS_RSVD_A, `DBC_OFS_SUBSYS,
      `DBC_OFS_RSVD_B, `DBC_OFS_CAP, `DBC_OFS_ROM: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error, never a silent write
  assign pslverr = xfer && !mapped;

  // both halves must be enabled; a stale upper mask also kills a 32-bit window
  assign window_en = setup.mask_lo[`DBC_SETUP_EN_BIT] && setup.mask_hi[`DBC_SETUP_EN_BIT];

  // non-writable base bits read back zero so sizing by all-ones works; type bits show the setup code
  always_comb begin
    base_lo_word = `DBC_ZERO32;
    base_lo_word[`DBC_BASE_MSB:`DBC_BASE_LSB] = st_reg.base_lo & mask_lo;
    base_lo_word[`DBC_TYPE_MSB:`DBC_TYPE_LSB] = st_reg.addr_type;
  end

  always_comb begin
    rd_word = `DBC_ZERO32;
    unique case (paddr)
      `DBC_OFS_BASE: rd_word = base_lo_word;
      `DBC_OFS_UPPER: rd_word = st_reg.base_hi & setup.mask_hi;
      `DBC_OFS_SUBSYS: rd_word = {setup.sub_device, setup.sub_vendor};
      `DBC_OFS_CAP: rd_word = {24'h000000, `DBC_CAP_PTR};
      `DBC_OFS_ROM: rd_word = `DBC_ROM_VALUE;
      default: rd_word = `DBC_ZERO32;
    endcase
  end

  assign prdata = rd_en ? rd_word : `DBC_ZERO32;

  // window compare, granularity 4KB; address bits 31 and 63 are always compared, since the enable bits sit in the masks
  assign hit32 = window_en && (st_reg.addr_type == `DBC_TYPE_32) &&
                 (req.addr[63:32] == `DBC_ZERO32) &&
                 ((req.addr[31:12] & mask_lo) == (st_reg.base_lo & mask_lo));
  assign hit64 = window_en && (st_reg.addr_type == `DBC_TYPE_64) &&
                 ((req.addr[63:32] & setup.mask_hi) == (st_reg.base_hi & setup.mask_hi)) &&
                 ((req.addr[31:12] & mask_lo) == (st_reg.base_lo & mask_lo));
  assign xlat_lo = (setup.xlat_base & {mask_lo, 12'h000}) |
                   (req.addr[31:0] & ~{mask_lo, 12'h000});

  always_comb begin
    st_next = st_reg;
    // width field follows the loaded setup code
    st_next.addr_type = setup.mask_lo[`DBC_TYPE_MSB:`DBC_TYPE_LSB];
    if (wr_en && (paddr == `DBC_OFS_BASE)) begin
      st_next.base_lo = (st_reg.base_lo & ~mask_lo) |
                        (pwdata[`DBC_BASE_MSB:`DBC_BASE_LSB] & mask_lo);
    end
    if (wr_en && (paddr == `DBC_OFS_UPPER)) begin
      st_next.base_hi = (st_reg.base_hi & ~setup.mask_hi) | (pwdata & setup.mask_hi);
    end
    st_next.res.valid = req.valid;
    st_next.res.hit = req.valid && (hit32 || hit64);
    if (req.valid && hit32) begin
      st_next.res.addr = {`DBC_ZERO32, xlat_lo};
    end else begin
      st_next.res.addr = req.addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.base_lo <= `DBC_BASE_RST;
      st_reg.base_hi <= `DBC_UPPER_RST;
      st_reg.addr_type <= `DBC_TYPE_RST;
      st_reg.res <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign res = st_reg.res;

  // checks

  a_base_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_BASE) |->
      (prdata[0] == 1'b0 && prdata[3] == 1'b0 && prdata[11:4] == 8'h00))
    else $error("base low bits not zero");

  a_type_field_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_BASE) |->
      prdata[2:1] == st_reg.addr_type)
    else $error("type field mismatch");

  a_base_masked_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `DBC_OFS_BASE) |=>
      (st_reg.base_lo & $past(mask_lo)) == ($past(pwdata[31:12]) & $past(mask_lo)) &&
      (st_reg.base_lo & ~$past(mask_lo)) == ($past(st_reg.base_lo) & ~$past(mask_lo)))
    else $error("base write ignored mask");

  a_upper_masked_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `DBC_OFS_UPPER) |=>
      (st_reg.base_hi & ~$past(setup.mask_hi)) ==
      ($past(st_reg.base_hi) & ~$past(setup.mask_hi)))
    else $error("upper read-only bit changed");

  a_disabled_no_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && !window_en) |=> (res.valid && !res.hit))
    else $error("hit while window off");

  a_xlat_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && hit32) |=>
      (res.hit && res.addr[63:32] == 32'h00000000 &&
       res.addr[11:0] == $past(req.addr[11:0])))
    else $error("32-bit translation wrong");

  a_pass_unchanged: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && hit64) |=> (res.hit && res.addr == $past(req.addr)))
    else $error("64-bit address altered");

  a_subsys_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_SUBSYS) |->
      prdata == {setup.sub_device, setup.sub_vendor})
    else $error("subsystem id wrong");

  a_cap_ptr_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_CAP) |-> prdata == 32'h00000080)
    else $error("capability pointer wrong");

  a_rsvd_rom_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && (paddr == `DBC_OFS_ROM || paddr == `DBC_OFS_RSVD_A ||
               paddr == `DBC_OFS_RSVD_B)) |-> prdata == 32'h00000000)
    else $error("reserved or rom not zero");

  a_rsvd_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == `DBC_OFS_RSVD_A || paddr == `DBC_OFS_RSVD_B)) |=>
      (st_reg.base_lo == $past(st_reg.base_lo) && st_reg.base_hi == $past(st_reg.base_hi)))
    else $error("reserved write had effect");

  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> (st_reg == $past(st_reg)))
    else $error("state moved while frozen");

  // register bus side

  a_upper_write_land: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `DBC_OFS_UPPER) |=>
      (st_reg.base_hi & $past(setup.mask_hi)) == ($past(pwdata) & $past(setup.mask_hi)))
    else $error("upper writable bit not written");

  a_upper_read_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_UPPER) |->
      prdata == (st_reg.base_hi & setup.mask_hi))
    else $error("upper read wrong");

  a_base_read_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_BASE) |->
      prdata[31:12] == (st_reg.base_lo & mask_lo))
    else $error("base read wrong");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer && !mapped) |->
      (pslverr && prdata == 32'h00000000))
    else $error("unmapped access not refused");

  a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer && mapped) |->
      !pslverr)
    else $error("mapped access refused");

  a_ready_follows_en: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |->
      pready == clk_en)
    else $error("ready not tied to enable");

  a_idle_prdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_en |->
      prdata == 32'h00000000)
    else $error("read data outside read access");

  a_idle_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    !xfer |->
      !pslverr)
    else $error("error outside access");

  a_err_in_access: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |->
      (psel && penable && clk_en))
    else $error("error without access phase");

  a_frozen_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |->
      (!pready && !pslverr && prdata == 32'h00000000))
    else $error("bus answered while frozen");

  a_type_tracks_setup: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=>
      st_reg.addr_type == $past(setup.mask_lo[2:1]))
    else $error("type field not following setup");

  a_base_no_stray: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !(wr_en && paddr == `DBC_OFS_BASE)) |=>
      st_reg.base_lo == $past(st_reg.base_lo))
    else $error("base changed without write");

  a_upper_no_stray: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !(wr_en && paddr == `DBC_OFS_UPPER)) |=>
      st_reg.base_hi == $past(st_reg.base_hi))
    else $error("upper changed without write");

  a_rom_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_ROM) |->
      prdata == `DBC_ROM_VALUE)
    else $error("rom base not zero");

  a_cap_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFS_CAP) |->
      prdata[31:8] == 24'h000000)
    else $error("capability high bits set");

  a_err_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !mapped) |=>
      (st_reg.base_lo == $past(st_reg.base_lo) && st_reg.base_hi == $past(st_reg.base_hi)))
    else $error("refused write had effect");

  a_ro_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == `DBC_OFS_SUBSYS || paddr == `DBC_OFS_CAP || paddr == `DBC_OFS_ROM)) |=>
      (st_reg.base_lo == $past(st_reg.base_lo) && st_reg.base_hi == $past(st_reg.base_hi)))
    else $error("read-only write had effect");

  // reset acts without a clock, so this one ignores the disable

  a_reset_values: assert property (@(posedge pclk)
    !presetn |->
      (st_reg.base_lo == `DBC_BASE_RST && st_reg.base_hi == `DBC_UPPER_RST &&
       st_reg.addr_type == `DBC_TYPE_RST && !st_reg.res.valid))
    else $error("state not at reset value");

  // decoder side

  a_rsvd_type_no_hit: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg.addr_type[1] |->
      (!hit32 && !hit64))
    else $error("reserved type code decoded");

  a_hit32_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
    hit32 |->
      req.addr[63:32] == 32'h00000000)
    else $error("32-bit hit above 4GB");

  a_xlat_base_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && hit32) |=>
      (res.addr[31:12] & $past(mask_lo)) == ($past(setup.xlat_base[31:12]) & $past(mask_lo)))
    else $error("translated base bits wrong");

  a_xlat_offset_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && hit32) |=>
      (res.addr[31:12] & ~$past(mask_lo)) == ($past(req.addr[31:12]) & ~$past(mask_lo)))
    else $error("window offset lost in translation");

  a_miss_unchanged: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && !hit32) |=>
      res.addr == $past(req.addr))
    else $error("untranslated address altered");

  a_res_valid_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=>
      res.valid == $past(req.valid))
    else $error("answer not one cycle after request");

  a_hit_needs_valid: assert property (@(posedge pclk) disable iff (!presetn)
    res.hit |->
      res.valid)
    else $error("hit without answer");

  a_off_no_decode: assert property (@(posedge pclk) disable iff (!presetn)
    !window_en |->
      (!hit32 && !hit64))
    else $error("decode while window off");

  a_lo_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && !setup.mask_lo[`DBC_SETUP_EN_BIT]) |=>
      !res.hit)
    else $error("hit with lower enable clear");

  a_hi_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && req.valid && !setup.mask_hi[`DBC_SETUP_EN_BIT]) |=>
      !res.hit)
    else $error("hit with upper enable clear");

  a_modes_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    hit32 |->
      !hit64)
    else $error("both decode widths hit");

  a_hit32_type: assert property (@(posedge pclk) disable iff (!presetn)
    hit32 |->
      st_reg.addr_type == `DBC_TYPE_32)
    else $error("32-bit hit in wrong mode");

  a_hit64_type: assert property (@(posedge pclk) disable iff (!presetn)
    hit64 |->
      st_reg.addr_type == `DBC_TYPE_64)
    else $error("64-bit hit in wrong mode");

  a_hit64_upper_match: assert property (@(posedge pclk) disable iff (!presetn)
    hit64 |->
      (req.addr[63:32] & setup.mask_hi) == (st_reg.base_hi & setup.mask_hi))
    else $error("upper half mismatch on hit");

  a_hit_low_match: assert property (@(posedge pclk) disable iff (!presetn)
    (hit32 || hit64) |->
      (req.addr[31:12] & mask_lo) == (st_reg.base_lo & mask_lo))
    else $error("lower half mismatch on hit");

endmodule

//--- hw/dbc_params.svh
// Purpose: offsets, field positions, reset values and fixed codes of the window-three header slice
// Assumes: byte addresses on a 32-bit apb bus, one aligned word per register
// Notes: definitions only
`ifndef DBC_PARAMS_SVH
`define DBC_PARAMS_SVH

`define DBC_AW 12
`define DBC_OFS_BASE 12'h020
`define DBC_OFS_UPPER 12'h024
`define DBC_OFS_RSVD_A 12'h028
`define DBC_OFS_SUBSYS 12'h02c
`define DBC_OFS_RSVD_B 12'h030
`define DBC_OFS_CAP 12'h034
`define DBC_OFS_ROM 12'h038

`define DBC_BASE_MSB 31
`define DBC_BASE_LSB 12
`define DBC_TYPE_MSB 2
`define DBC_TYPE_LSB 1
`define DBC_SETUP_EN_BIT 31

`define DBC_BASE_RST 20'h00000
`define DBC_UPPER_RST 32'h00000000
`define DBC_TYPE_RST 2'h0
`define DBC_TYPE_32 2'h0
`define DBC_TYPE_64 2'h1
`define DBC_CAP_PTR 8'h80
`define DBC_ROM_VALUE 32'h00000000
`define DBC_ZERO32 32'h00000000
`define DBC_ZERO20 20'h00000

`endif

//--- hw/dbc_pkg.sv
// Purpose: types shared by the window-three header slice
// Assumes: dbc_params.svh holds all numbers
// Notes: carriers for the address check port and the module state
package dbc_pkg;

  // address offered to the window decoder
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } dbc_req_type;

  // decoder answer, one cycle after the request
  typedef struct packed {
    logic valid;
    logic hit;
    logic [63:0] addr;
  } dbc_res_type;

  // setup values loaded from eeprom, smbus or local processor
  typedef struct packed {
    logic [31:0] mask_lo;
    logic [31:0] mask_hi;
    logic [31:0] xlat_base;
    logic [15:0] sub_vendor;
    logic [15:0] sub_device;
  } dbc_setup_type;

  typedef struct packed {
    logic [19:0] base_lo;
    logic [31:0] base_hi;
    logic [1:0] addr_type;
    dbc_res_type res;
  } dbc_state_type;

endpackage

//--- test/tb.sv
// Purpose: self-checking bench for the window-three header slice
// Assumes: apb slave with wait states only while clk_en is low, setup inputs driven by the bench
// Notes: lfsr stimulus seeded with 8; one freeze span stalls a read and a decode
`timescale 1ns/10ps
`include "dbc_params.svh"
module tb;
  import dbc_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [`DBC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, lf, rd, m, mh, bl, bh, w;
  logic [63:0] a;
  logic [11:0] ofs [7];
  logic [31:0] ev [7];
  dbc_setup_type setup;
  dbc_req_type req;
  dbc_res_type res;
  int error_cnt, check_count;
  dbc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .setup(setup), .req(req), .res(res));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  // unwritable base and flag bits read back as zero, type bits show the setup code
  function automatic logic [31:0] base_rd(input logic [31:0] v);
    return {v[31:12] & m[31:12], 8'h00, 1'b0, setup.mask_lo[2:1], 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one idle cycle first, so psel is never released and raised in one step
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dec(input logic [63:0] ad, input logic eh, input logic [63:0] ea);
    @(posedge pclk);
    req <= '{valid: 1'b1, addr: ad};
    @(posedge pclk);
    req.valid <= 1'b0;
    @(negedge pclk);
    chk("res_valid", 64'h1, res.valid);
    chk("res_hit", eh, res.hit);
    if (eh) chk("res_addr", ea, res.addr);
  endtask
  initial begin
    lf = 32'h8;
    error_cnt = 0;
    check_count = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    req = '0;
    m = 32'h80000000;
    // subsystem ids are arbitrary
    setup = '{mask_lo: m, mask_hi: m, xlat_base: rnd(), sub_vendor: 16'h1a2b, sub_device: 16'h3c4d};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DBC_OFS_BASE, 32'h0);
    chk("base_reset", base_rd(32'h0), rd);
    apb(1'b0, `DBC_OFS_UPPER, 32'h0);
    chk("upper_reset", 64'h0, rd);
    for (int t = 0; t < 2; t++) begin
      w = rnd();
      m = {1'b1, w[30:12], 12'h000};
      w = rnd();
      mh = {1'b1, w[30:0]};
      @(posedge pclk);
      setup.mask_lo <= {m[31:12], 9'h000, 1'b0, t[0], 1'b0};
      setup.mask_hi <= mh;
      repeat (4) begin
        bl = rnd();
        apb(1'b1, `DBC_OFS_BASE, bl);
        apb(1'b0, `DBC_OFS_BASE, 32'h0);
        chk("base_rd", base_rd(bl), rd);
        bh = rnd();
        apb(1'b1, `DBC_OFS_UPPER, bh);
        apb(1'b0, `DBC_OFS_UPPER, 32'h0);
        chk("upper_rd", bh & mh, rd);
      end
      w = rnd();
      a = {(bh & mh) | (w & ~mh), {bl[31:12], 12'h000} & m | (w & ~m)};
      if (t == 0) begin
        a[63:32] = 32'h0;
        dec(a, 1'b1, {32'h0, (setup.xlat_base & m) | (a[31:0] & ~m)});
      end else begin
        dec(a, 1'b1, a);
      end
      dec(a ^ 64'h80000000, 1'b0, 64'h0);
    end
    @(posedge pclk);
    setup.mask_hi[31] <= 1'b0;
    dec(a, 1'b0, 64'h0);
    @(posedge pclk);
    setup.mask_hi[31] <= 1'b1;
    setup.mask_lo[31] <= 1'b0;
    dec(a, 1'b0, 64'h0);
    // frozen enable: the read must wait and the decoder must not answer
    @(posedge pclk);
    clk_en <= 1'b0;
    setup.mask_lo[2:1] <= 2'h0;
    req <= '{valid: 1'b1, addr: a};
    fork
      apb(1'b0, `DBC_OFS_CAP, 32'h0);
      begin
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("pready_frozen", 64'h0, pready);
        chk("res_frozen", 64'h0, res.valid);
        @(posedge pclk);
        clk_en <= 1'b1;
        req.valid <= 1'b0;
        setup.mask_lo[2:1] <= 2'h1;
      end
    join
    chk("cap_after_freeze", {24'h0, `DBC_CAP_PTR}, rd);
    ofs = '{12'h028, 12'h02c, 12'h030, 12'h034, 12'h038, 12'h03c, 12'h000};
    ev = '{32'h0, {setup.sub_device, setup.sub_vendor}, 32'h0, {24'h0, `DBC_CAP_PTR}, 32'h0,
      32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ofs[i], rnd());
      apb(1'b0, ofs[i], 32'h0);
      chk("fixed_rd", ev[i], rd);
      chk("slverr", i > 4, er);
    end
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DBC_OFS_UPPER, 32'h0);
    chk("upper_rst2", 64'h0, rd);
    apb(1'b0, `DBC_OFS_BASE, 32'h0);
    chk("base_rst2", base_rd(32'h0), rd);
    print_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule
